// ==== rtl/nvres_pkg.sv ====
// Shared constants and types for the triple resistor serial slave.
// Assumes a 40 MHz core clock; the shifter, core and bench import this package.
package nvres_pkg;

	// Register map of the three resistor settings
	localparam int          NUM_RES     = 3;
	localparam logic [7:0]  RES0_ADDR   = 8'hf8;
	localparam logic [7:0]  RES1_ADDR   = 8'hf9;
	localparam logic [7:0]  RES2_ADDR   = 8'hfa;
	localparam int          HIZ_BIT     = 7;
	localparam logic [7:0]  POS_MAX     = 8'h7f;
	localparam logic [7:0]  FACTORY_VAL = 8'h00;
	localparam logic [7:0]  RD_UNMAPPED = 8'h00;

	// Device address byte layout
	localparam logic [3:0]  DEV_ID      = 4'ha;
	localparam logic [1:0]  SINGLE_PAD  = 2'h0;
	localparam int          RW_BIT      = 0;
	localparam logic [3:0]  BYTE_BITS   = 4'h8;

	// Nonvolatile write time
	localparam int          CLK_MHZ     = 40;
	localparam int          NVW_TIME_US = 20000;
	localparam int          NVW_CYCLES  = NVW_TIME_US * CLK_MHZ;

	// Protocol states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_RX   = 7'h02,
		ST_ACK  = 7'h04,
		ST_TX   = 7'h08,
		ST_MACK = 7'h10,
		ST_WAIT = 7'h20,
		ST_NVW  = 7'h40
	} nvres_state_t;

	// Which byte of a transfer is being received
	typedef enum logic [1:0] {
		BK_DEV  = 2'h0,
		BK_REG  = 2'h1,
		BK_DATA = 2'h2
	} nvres_byte_t;

endpackage : nvres_pkg

// ==== rtl/nvres_link_if.sv ====
// Carrier between the core and the serial-clock shifter.
// Assumes the core feeds the raw bus pins in and reads the shifted byte.
interface nvres_link_if;
	logic       scl;
	logic       sda;
	logic [7:0] shift;

	modport link (input scl, input sda, output shift);
	modport core (output scl, output sda, input shift);
endinterface : nvres_link_if

// ==== rtl/nvres_link_shift.sv ====
// Serial-clock domain shifter: samples the data line on each clock rise.
// Assumes the core only reads the byte while the serial clock is low.
module nvres_link_shift
	import nvres_pkg::*;
(
	nvres_link_if.link lnk
);

	logic [7:0] shift_ff;

	// Data is taken MSB first on every rising serial clock edge
	always_ff @(posedge lnk.scl)
	begin
		shift_ff <= {shift_ff[6:0], lnk.sda};
	end

	assign lnk.shift = shift_ff;

endmodule : nvres_link_shift

// ==== rtl/nvres_core.sv ====
// Two-wire slave core with three resistor settings and a timed NV write.
// Assumes scl_i is the master's clock, used as the shifter's own domain,
// and that an external pull-up resolves sda from sda_oe_o.
//
// Contract
// [RULE1] Resistor 0, 1 and 2 settings live at addresses F8h, F9h, FAh.
// [RULE2] Codes 00h to 7Fh pick one of 128 positions; above 7Fh sets high-Z.
// [RULE3] Setting MSB is the high-Z bit: 80h opens, 00h gives low state.
// [RULE4] SDA falling while SCL high is a start, needed before any command.
// [RULE5] SDA rising while SCL high is a stop, returning device to standby.
// [RULE6] SDA changes only while SCL low; high-phase changes are start/stop.
// [RULE7] Device pulls SDA low for the whole ninth pulse after each byte.
// [RULE8] Standby after power-on, after stop, and after internal work ends.
// [RULE9] Master recovers the bus with up to nine clocks and a start.
// [RULE10] Single-pin variant address is 101000, select bit 0, direction.
// [RULE11] Three-pin variant address is 1010, select bits 2..0, direction.
// [RULE12] Direction high starts a read; direction low starts a write.
// [RULE13] Acknowledge only matching select bits; else silent and standby.
// [RULE14] Write sends register address then data, each acknowledged.
// [RULE15] Master ends a write with a stop after the data acknowledge.
// [RULE16] Stop after a write starts a timed NV write ignoring the bus.
// [RULE17] No address acknowledge while the NV write is running.
// [RULE18] Master may instead wait the maximum write time.
// [RULE19] Read is a dummy write of the address, repeated start, read.
// [RULE20] On a matching read the device acks, then shifts out one byte.
// [RULE21] Master answers the read byte with a NACK and a stop.
// [RULE22] SDA is only pulled low or released; SCL is only an input.
// [RULE23] Settings are restored from NV storage at power-up.
module nvres_core
	import nvres_pkg::*;
#(
	parameter bit THREE_SEL = 1'b1,
	parameter int NVW_CYC   = NVW_CYCLES
)(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       select_pin_bit0_i,
	input  wire logic       select_pin_bit1_i,
	input  wire logic       select_pin_bit2_i,
	input  wire logic       nv_erase_i,
	output logic [7:0]      resistor0_setting_o,
	output logic [7:0]      resistor1_setting_o,
	output logic [7:0]      resistor2_setting_o,
	output logic            busy_o,
	output logic            standby_o
);

	localparam int CW = $clog2(NVW_CYC + 1);

	nvres_link_if lnk ();

	nvres_state_t state_ff;
	nvres_byte_t  kind_ff;
	logic [2:0]   scl_sy_ff;
	logic [2:0]   sda_sy_ff;
	logic [2:0]   sel_s1_ff;
	logic [2:0]   sel_s2_ff;
	logic [3:0]   bitcnt_ff;
	logic [7:0]   tx_sh_ff;
	logic         sda_oe_ff;
	logic [7:0]   ptr_ff;
	logic [7:0]   wr_data_ff;
	logic         wr_pend_ff;
	logic [CW-1:0] nvw_cnt_ff;
	logic [7:0]   setting_ff [NUM_RES];
	logic [7:0]   nv_mem_ff  [NUM_RES];

	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;
	logic         byte_done;
	logic [7:0]   rx_byte;
	logic         addr_match;
	logic [2:0]   sel_exp;
	logic         commit;
	logic         nvw_done;

	// Raw pins feed the serial-clock shifter
	assign lnk.scl = scl_i;
	assign lnk.sda = sda_i;

	nvres_link_shift u_shift (
		.lnk (lnk.link)
	);

	// Two-stage synchronisers, third stage only for edge detection
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			scl_sy_ff <= 3'h7;
			sda_sy_ff <= 3'h7;
			sel_s1_ff <= 3'h0;
			sel_s2_ff <= 3'h0;
		end
		else
		begin
			scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
			sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
			sel_s1_ff <= {select_pin_bit2_i, select_pin_bit1_i,
				select_pin_bit0_i};
			sel_s2_ff <= sel_s1_ff;
		end
	end

	// Bus events seen on synchronised lines
	assign scl_rise  = scl_sy_ff[1] & ~scl_sy_ff[2];
	assign scl_fall  = ~scl_sy_ff[1] & scl_sy_ff[2];
	assign start_det = scl_sy_ff[1] & scl_sy_ff[2]
		& sda_sy_ff[2] & ~sda_sy_ff[1]; // RULE4
	assign stop_det  = scl_sy_ff[1] & scl_sy_ff[2]
		& ~sda_sy_ff[2] & sda_sy_ff[1]; // RULE5

	// Shifter is stable from its last rise until the next one
	assign rx_byte   = lnk.shift;
	assign byte_done = (state_ff == ST_RX) && scl_fall
		&& (bitcnt_ff == BYTE_BITS); // RULE6

	// Device address compare per variant
	assign sel_exp    = THREE_SEL ? sel_s2_ff
		: {SINGLE_PAD, sel_s2_ff[0]}; // RULE10 RULE11
	assign addr_match = (rx_byte[7:4] == DEV_ID)
		&& (rx_byte[3:1] == sel_exp); // RULE13

	// Commit of a finished write at its closing stop
	assign commit   = (state_ff == ST_WAIT) && stop_det && wr_pend_ff
		&& ((ptr_ff == RES0_ADDR) || (ptr_ff == RES1_ADDR)
		|| (ptr_ff == RES2_ADDR)); // RULE16
	assign nvw_done = (state_ff == ST_NVW)
		&& (nvw_cnt_ff == CW'(NVW_CYC - 1));

	// Read data selection by register pointer
	function automatic logic [7:0] rd_sel(input logic [7:0] a);
		logic [7:0] r;
		r = RD_UNMAPPED;
		if (a == RES0_ADDR)
			r = setting_ff[0];
		else if (a == RES1_ADDR)
			r = setting_ff[1];
		else if (a == RES2_ADDR)
			r = setting_ff[2]; // RULE1
		return r;
	endfunction : rd_sel

	// Protocol state machine and data line drive
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff   <= ST_IDLE; // RULE8
			kind_ff    <= BK_DEV;
			bitcnt_ff  <= 4'h0;
			tx_sh_ff   <= 8'h00;
			sda_oe_ff  <= 1'b0;
			ptr_ff     <= 8'h00;
			wr_data_ff <= 8'h00;
			wr_pend_ff <= 1'b0;
		end
		else if (state_ff == ST_NVW)
		begin
			sda_oe_ff <= 1'b0; // RULE16 RULE17
			if (nvw_done)
				state_ff <= ST_IDLE; // RULE8
		end
		else if (start_det)
		begin
			state_ff   <= ST_RX; // RULE4
			kind_ff    <= BK_DEV;
			bitcnt_ff  <= 4'h0;
			sda_oe_ff  <= 1'b0;
			wr_pend_ff <= 1'b0;
		end
		else if (stop_det)
		begin
			state_ff   <= commit ? ST_NVW : ST_IDLE; // RULE5 RULE16
			sda_oe_ff  <= 1'b0;
			wr_pend_ff <= 1'b0;
		end
		else
		begin
			case (state_ff)
				ST_RX:
				begin
					if (scl_rise)
						bitcnt_ff <= bitcnt_ff + 4'h1;
					if (byte_done)
					begin
						bitcnt_ff <= 4'h0;
						if (kind_ff == BK_DEV)
						begin
							if (addr_match)
							begin
								state_ff  <= ST_ACK; // RULE7
								sda_oe_ff <= 1'b1;
								// Direction picks read or write
								kind_ff   <= rx_byte[RW_BIT]
									? BK_DEV : BK_REG; // RULE12
								tx_sh_ff  <= rd_sel(ptr_ff);
							end
							else
								state_ff <= ST_IDLE; // RULE13
						end
						else if (kind_ff == BK_REG)
						begin
							ptr_ff    <= rx_byte; // RULE14
							kind_ff   <= BK_DATA;
							state_ff  <= ST_ACK;
							sda_oe_ff <= 1'b1;
						end
						else
						begin
							wr_data_ff <= rx_byte; // RULE14
							wr_pend_ff <= 1'b1;
							state_ff   <= ST_ACK;
							sda_oe_ff  <= 1'b1;
						end
					end
				end
				ST_ACK:
				begin
					// End of the ninth pulse releases the line, or drives the first bit of a read
					if (scl_fall)
					begin
						if (wr_pend_ff)
						begin
							state_ff  <= ST_WAIT; // RULE15
							sda_oe_ff <= 1'b0;
						end
						else if (kind_ff == BK_DEV)
						begin
							state_ff  <= ST_TX; // RULE20
							sda_oe_ff <= ~tx_sh_ff[7]; // RULE22
						end
						else
						begin
							state_ff  <= ST_RX;
							sda_oe_ff <= 1'b0;
						end
					end
				end
				ST_TX:
				begin
					if (scl_rise)
						bitcnt_ff <= bitcnt_ff + 4'h1;
					if (scl_fall)
					begin
						if (bitcnt_ff == BYTE_BITS)
						begin
							state_ff  <= ST_MACK; // RULE21
							sda_oe_ff <= 1'b0;
							bitcnt_ff <= 4'h0;
						end
						else
						begin
							tx_sh_ff  <= {tx_sh_ff[6:0], 1'b0};
							sda_oe_ff <= ~tx_sh_ff[6]; // RULE20
						end
					end
				end
				ST_MACK:
				begin
					if (scl_fall)
						state_ff <= ST_WAIT;
				end
				default:
				begin
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// Self-timed nonvolatile write counter
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || (state_ff != ST_NVW))
			nvw_cnt_ff <= '0;
		else
			nvw_cnt_ff <= nvw_cnt_ff + CW'(1); // RULE16
	end

	// Live settings and their nonvolatile copies, one per resistor
	for (genvar g = 0; g < NUM_RES; g++)
	begin : g_res
		localparam logic [7:0] ADDR = RES0_ADDR + 8'(g);

		always_ff @(posedge clk_i)
		begin
			if (!rst_n_i)
				setting_ff[g] <= nv_mem_ff[g]; // RULE23
			else if (commit && (ptr_ff == ADDR))
				setting_ff[g] <= wr_data_ff; // RULE2 RULE3
		end

		always_ff @(posedge clk_i)
		begin
			if (nv_erase_i)
				nv_mem_ff[g] <= FACTORY_VAL;
			else if (nvw_done && (ptr_ff == ADDR))
				nv_mem_ff[g] <= setting_ff[g]; // RULE16
		end
	end

	// Outputs
	assign sda_o               = 1'b0; // RULE22
	assign sda_oe_o            = sda_oe_ff;
	assign resistor0_setting_o = setting_ff[0];
	assign resistor1_setting_o = setting_ff[1];
	assign resistor2_setting_o = setting_ff[2];
	assign busy_o              = (state_ff == ST_NVW);
	assign standby_o           = (state_ff == ST_IDLE);

	// Checks
	ack_drive_a: assert property (@(posedge clk_i) // RULE7
		disable iff (!rst_n_i)
		(state_ff == ST_ACK) |-> sda_oe_ff)
		else $error("ack slot not driven low");

	nvw_silent_a: assert property (@(posedge clk_i) // RULE17
		disable iff (!rst_n_i)
		$past(state_ff == ST_NVW) && (state_ff == ST_NVW) |-> !sda_oe_ff)
		else $error("line driven during nv write");

	start_rx_a: assert property (@(posedge clk_i) // RULE4
		disable iff (!rst_n_i)
		start_det && (state_ff != ST_NVW)
		|=> (state_ff == ST_RX) && (bitcnt_ff == 4'h0) && (kind_ff == BK_DEV))
		else $error("start not taken");

	stop_idle_a: assert property (@(posedge clk_i) // RULE5
		disable iff (!rst_n_i)
		stop_det && !commit && (state_ff != ST_NVW)
		|=> (state_ff == ST_IDLE) && !sda_oe_ff)
		else $error("stop did not return to standby");

	mismatch_a: assert property (@(posedge clk_i) // RULE13
		disable iff (!rst_n_i)
		byte_done && (kind_ff == BK_DEV) && !addr_match && !start_det
		&& !stop_det |=> (state_ff == ST_IDLE) && !sda_oe_ff)
		else $error("foreign address answered");

	write_apply_a: assert property (@(posedge clk_i) // RULE1
		disable iff (!rst_n_i)
		commit && (ptr_ff == RES1_ADDR)
		|=> (setting_ff[1] == $past(wr_data_ff)) && busy_o)
		else $error("write not applied");

	// Both halves are separate implications, joined explicitly
	nvw_len_a: assert property (@(posedge clk_i) // RULE16
		disable iff (!rst_n_i)
		($rose(state_ff == ST_NVW) |-> (nvw_cnt_ff == '0))
		and ((state_ff == ST_NVW) |-> (nvw_cnt_ff < CW'(NVW_CYC))))
		else $error("nv write time wrong");

	tx_bit_a: assert property (@(posedge clk_i) // RULE20
		disable iff (!rst_n_i)
		(state_ff == ST_TX) |-> (sda_oe_ff == ~tx_sh_ff[7]))
		else $error("read bit mismatch");

	oe_low_phase_a: assert property (@(posedge clk_i) // RULE6
		disable iff (!rst_n_i)
		$changed(sda_oe_ff) && !$past(start_det) && !$past(stop_det)
		|-> !scl_sy_ff[2])
		else $error("data changed while clock high");

endmodule : nvres_core

// ==== verif/nvres_master_model.sv ====
// Behavioural two-wire bus master for the resistor serial slave.
// Assumes a pull-up on the data line, resolved by the bench.
module nvres_master_model
(
	output logic      scl_o,
	output logic      sda_pull_o,
	input  wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam time T_LO = 200ns;
	localparam time T_HI = 40ns;

	// Idle bus: clock stands high, data released
	initial
	begin
		scl_o      = 1'b1;
		sda_pull_o = 1'b0;
	end

	// Start or repeated start: data falls while clock is high
	task automatic start_c;
		sda_pull_o = 1'b0;
		#T_LO scl_o = 1'b1;
		#T_LO sda_pull_o = 1'b1;
		#T_LO scl_o = 1'b0;
	endtask : start_c

	// Stop: data rises while clock is high, clock then stands still
	task automatic stop_c;
		sda_pull_o = 1'b1;
		#T_LO scl_o = 1'b1;
		#T_LO sda_pull_o = 1'b0;
		#T_LO;
	endtask : stop_c

	// One bit; the line is read low only if low at both samples, 5 ns and 35 ns into the high phase
	task automatic bit_c(input logic b, output logic r);
		sda_pull_o = ~b;
		#T_LO scl_o = 1'b1;
		#5 r = sda_i;
		#(T_HI - 10) r = r | sda_i;
		#5 scl_o = 1'b0;
	endtask : bit_c

	// Byte MSB first, ninth bit released: ack from a receiver, NACK on read
	task automatic byte_c(input logic [7:0] d, output logic [7:0] q,
		output logic ack);
		logic t;
		for (int i = 7; i >= 0; i--)
		begin
			bit_c(d[i], t);
			q = {q[6:0], t};
		end
		bit_c(1'b1, t);
		ack = ~t;
	endtask : byte_c

	// Recovery: nine released clocks, then a start
	task automatic bus_reset;
		logic r;
		repeat (9) bit_c(1'b1, r);
		sda_pull_o = 1'b0;
		start_c;
	endtask : bus_reset
endmodule : nvres_master_model

// ==== verif/triple_nv_resistor_serial_slave_tb.sv ====
// Self-checking bench for the triple resistor serial slave core.
// Assumes the master model owns the bus clock; the bench resolves data.
module triple_nv_resistor_serial_slave_tb
	import nvres_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         NVW = 400;
	localparam logic [2:0] SEL = 3'h5;
	logic       clk_i, rst_n_i, nv_erase_i, sda_o, sda_oe_o;
	logic       busy_o, standby_o, scl, m_pull, sda;
	logic [2:0] sel;
	logic [7:0] rs [0:2];
	logic       oe_b;
	logic [7:0] rs_b;
	int         fail_count = 0;
	int         num_checks = 0;

	// Open-drain data line with pull-up
	assign sda = ~(sda_oe_o | oe_b | m_pull);

	nvres_core #(.THREE_SEL(1'b1), .NVW_CYC(NVW)) uut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.select_pin_bit0_i(sel[0]), .select_pin_bit1_i(sel[1]),
		.select_pin_bit2_i(sel[2]), .nv_erase_i(nv_erase_i),
		.resistor0_setting_o(rs[0]), .resistor1_setting_o(rs[1]),
		.resistor2_setting_o(rs[2]), .busy_o(busy_o),
		.standby_o(standby_o));

	nvres_master_model mst (.scl_o(scl), .sda_pull_o(m_pull), .sda_i(sda));

	// Single-pin variant on the same bus; its upper straps must be ignored
	nvres_core #(.THREE_SEL(1'b0), .NVW_CYC(NVW)) u_single (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
		.sda_o(), .sda_oe_o(oe_b),
		.select_pin_bit0_i(1'b0), .select_pin_bit1_i(1'b1),
		.select_pin_bit2_i(1'b0), .nv_erase_i(nv_erase_i),
		.resistor0_setting_o(), .resistor1_setting_o(),
		.resistor2_setting_o(rs_b), .busy_o(), .standby_o());

	// Core clock, 25 ns
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : tick

	// Reset for six cycles, optionally blanking the stored copies
	task automatic do_reset(input logic er);
		tick(1);
		rst_n_i = 1'b0;
		nv_erase_i = er;
		tick(6);
		nv_erase_i = 1'b0;
		rst_n_i = 1'b1;
		tick(4);
	endtask : do_reset

	task automatic t_reset;
		do_reset(1'b1);
		for (int i = 0; i < 3; i++)
			chk("setting", FACTORY_VAL, rs[i]);
		chk("standby", 8'h1, {7'h0, standby_o});
		chk("sda value", 8'h0, {7'h0, sda_o});
	endtask : t_reset

	task automatic t_write(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       k;
		mst.start_c;
		mst.byte_c({DEV_ID, SEL, 1'b0}, q, k);
		chk("ack addr", 8'h1, {7'h0, k});
		mst.byte_c(a, q, k);
		chk("ack reg", 8'h1, {7'h0, k});
		mst.byte_c(d, q, k);
		chk("ack data", 8'h1, {7'h0, k});
		mst.stop_c;
		chk("busy", 8'h1, {7'h0, busy_o});
		mst.start_c;
		mst.byte_c({DEV_ID, SEL, 1'b0}, q, k);
		chk("poll ack", 8'h0, {7'h0, k});
		mst.stop_c;
		tick(NVW);
		chk("busy end", 8'h0, {7'h0, busy_o});
		chk("standby", 8'h1, {7'h0, standby_o});
		chk("setting", d, rs[int'(a - RES0_ADDR)]);
	endtask : t_write

	task automatic t_read(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic       k;
		mst.start_c;
		mst.byte_c({DEV_ID, SEL, 1'b0}, q, k);
		mst.byte_c(a, q, k);
		mst.start_c;
		mst.byte_c({DEV_ID, SEL, 1'b1}, q, k);
		chk("ack rd", 8'h1, {7'h0, k});
		mst.byte_c(8'hff, q, k);
		chk("rd data", e, q);
		mst.stop_c;
		chk("standby", 8'h1, {7'h0, standby_o});
	endtask : t_read

	// Each select bit flipped in turn, then a wrong identifier
	task automatic t_mismatch;
		logic [7:0] q;
		logic       k;
		for (int i = 0; i < 4; i++)
		begin
			mst.start_c;
			if (i < 3)
				mst.byte_c({DEV_ID, SEL ^ (3'h1 << i), 1'b0}, q, k);
			else
				mst.byte_c({4'hb, SEL, 1'b0}, q, k);
			chk("no ack", 8'h0, {7'h0, k});
			mst.stop_c;
			chk("standby", 8'h1, {7'h0, standby_o});
		end
	endtask : t_mismatch

	// Write abandoned after the address, bus recovered, nothing stored
	task automatic t_abort;
		logic [7:0] q;
		logic       k;
		mst.start_c;
		mst.byte_c({DEV_ID, SEL, 1'b0}, q, k);
		mst.bus_reset;
		mst.stop_c;
		chk("busy", 8'h0, {7'h0, busy_o});
		chk("setting", POS_MAX, rs[0]);
	endtask : t_abort

	// Single-pin part: padded select bits, strap bit 1 high but unused
	task automatic t_single;
		logic [7:0] q;
		logic       k;
		mst.start_c;
		mst.byte_c({DEV_ID, 3'h0, 1'b0}, q, k);
		chk("ack single", 8'h1, {7'h0, k});
		mst.byte_c(RES2_ADDR, q, k);
		mst.byte_c(8'h3c, q, k);
		mst.stop_c;
		tick(NVW);
		chk("single set", 8'h3c, rs_b);
		chk("other kept", 8'hc5, rs[2]);
		mst.start_c;
		mst.byte_c({DEV_ID, 3'h2, 1'b0}, q, k);
		chk("pad bits", 8'h0, {7'h0, k});
		mst.stop_c;
	endtask : t_single

	// Time-zero values and the test sequence
	initial
	begin
		rst_n_i = 1'b0;
		nv_erase_i = 1'b0;
		sel = SEL;
		t_reset;
		t_write(RES0_ADDR, POS_MAX);
		t_write(RES1_ADDR, 8'h80);
		t_write(RES2_ADDR, 8'hc5);
		t_read(RES0_ADDR, POS_MAX);
		t_read(RES1_ADDR, 8'h80);
		t_read(RES2_ADDR, 8'hc5);
		t_read(8'hfb, RD_UNMAPPED);
		t_mismatch;
		t_abort;
		t_single;
		t_write(RES0_ADDR, 8'h00);
		do_reset(1'b0);
		chk("restore", 8'h00, rs[0]);
		chk("restore", 8'h80, rs[1]);
		chk("restore", 8'hc5, rs[2]);
		chk("restore", 8'h3c, rs_b);
		end_sim;
	end

	// Hang guard, well beyond the expected run time
	initial
	begin
		#2ms;
		fail_count++;
		$display("[FAIL] watchdog exp done got timeout");
		end_sim;
	end
endmodule : triple_nv_resistor_serial_slave_tb
